// ### src/host_port_pkg.sv
package host_port_pkg;

  // widths of the host and shared memory paths
  localparam int ADDR_W          = 24;
  localparam int DATA_W          = 16;
  localparam int REG_ADDR_W      = 8;
  localparam int SEL_W           = 3;

  // buffering sizes
  localparam int WFIFO_DEPTH     = 4;
  localparam int FETCH_ENTRIES   = 4;

  // strap capture: cycles after reset release, past the two sync stages
  localparam logic [1:0] STRAP_CAPTURE_CYCLES = 2'h3;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;

  // host bus styles on the three select pins (pin 2, 1, 0)
  typedef enum logic [SEL_W-1:0] {
    ht_byte_mux_a   = 3'h3,
    ht_word_mux_a   = 3'h7,
    ht_word_sep_a   = 3'h4,
    ht_wide_sep     = 3'h0,
    ht_byte_mux_b   = 3'h1,
    ht_word_mux_b   = 3'h5,
    ht_word_sep_b   = 3'h6,
    ht_reserved     = 3'h2
  } host_type_t;

  // access sequencer states
  typedef enum logic [2:0] {
    st_idle     = 3'h0,
    st_reg      = 3'h1,
    st_rd_drain = 3'h2,
    st_rd_req   = 3'h3,
    st_rd_data  = 3'h4,
    st_wr_push  = 3'h5,
    st_done     = 3'h6
  } seq_state_t;

endpackage : host_port_pkg

// ### src/write_queue.sv
`timescale 1ns/100ps
`default_nettype none

module write_queue #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  // fill side
  input  wire logic             i_push_valid,
  output logic                  o_push_ready,
  input  wire logic [WIDTH-1:0] i_push_data,
  // drain side
  output logic                  o_pop_valid,
  input  wire logic             i_pop_ready,
  output logic      [WIDTH-1:0] o_pop_data,
  // levels
  output logic                  o_full,
  output logic                  o_empty
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_size_check
    $error("write_queue: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0]   count_r;

  wire push = i_push_valid & o_push_ready;
  wire pop  = o_pop_valid & i_pop_ready;

  assign o_full       = (count_r == (PTR_W+1)'(DEPTH));
  assign o_empty      = (count_r == '0);
  assign o_push_ready = ~o_full;
  assign o_pop_valid  = ~o_empty;
  assign o_pop_data   = mem_r[rd_ptr_r];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_push_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + PTR_W'(push);
      rd_ptr_r <= rd_ptr_r + PTR_W'(pop);
      count_r  <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

endmodule : write_queue

`default_nettype wire

// ### src/host_port_fetch_buffer.sv
// Notes on behaviour
// - at initialisation the host bus style is taken from the three select pins.
// - the pins code seven styles and code 0,1,0 is reserved and flagged.
// - the register chip select is decoded as an internal register access.
// - the memory chip select sends the access to shared memory through the buffers.
// - the buffers are used whatever host style is strapped.
// - there is one write queue and four read fetch memories.
// - a memory write puts address and data together into a four word queue.
// - a write to an address held in a fetch memory invalidates that copy.
// - queued writes finish on the host bus without waiting for the memory, except a write that finds the four word queue full.
// - memory read hits are answered from one of the four fetch memories, misses from the word read from shared memory.
// - a read that hits a valid fetch entry goes from idle straight to done, one cycle after it starts, with no shared memory access.
// - every returned memory word comes from shared memory, fetch entries are copies.
// - shared memory is reached by requesting the internal arbiter.
// - shared memory words and buffers are 16 bits wide.
`timescale 1ns/100ps
`default_nettype none

module host_port_fetch_buffer #(
  parameter int FIFO_DEPTH = host_port_pkg::WFIFO_DEPTH,
  parameter int ENTRIES    = host_port_pkg::FETCH_ENTRIES
) (
  // clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_rst_n,
  // strap pins
  input  wire logic [host_port_pkg::SEL_W-1:0]     i_host_type_select_pins,
  output logic      [host_port_pkg::SEL_W-1:0]     o_host_type,
  output logic                                     o_host_type_valid,
  output logic                                     o_host_type_reserved,
  // host bus pins
  input  wire logic                                i_register_chip_select_n,
  input  wire logic                                i_memory_chip_select_n,
  input  wire logic                                i_host_read_n,
  input  wire logic                                i_host_write_n,
  input  wire logic [host_port_pkg::ADDR_W-1:0]    i_host_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0]    i_host_data,
  output logic      [host_port_pkg::DATA_W-1:0]    o_host_data,
  output logic                                     o_host_data_oe,
  output logic                                     o_host_ready,
  // internal register file
  output logic                                     o_reg_req,
  output logic                                     o_reg_write,
  output logic      [host_port_pkg::REG_ADDR_W-1:0] o_reg_addr,
  output logic      [host_port_pkg::DATA_W-1:0]    o_reg_wdata,
  input  wire logic                                i_reg_ack,
  input  wire logic [host_port_pkg::DATA_W-1:0]    i_reg_rdata,
  // shared memory arbiter
  output logic                                     o_mem_req,
  output logic                                     o_mem_write,
  output logic      [host_port_pkg::ADDR_W-1:0]    o_mem_addr,
  output logic      [host_port_pkg::DATA_W-1:0]    o_mem_wdata,
  input  wire logic                                i_mem_gnt,
  input  wire logic                                i_mem_rvalid,
  input  wire logic [host_port_pkg::DATA_W-1:0]    i_mem_rdata
);

  import host_port_pkg::*;

  localparam int IDX_W = $clog2(ENTRIES);
  localparam int QW    = ADDR_W + DATA_W;
  localparam int PW    = SEL_W + 4 + ADDR_W + DATA_W;

  if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0 || FIFO_DEPTH < 2) begin : g_size_check
    $error("host_port_fetch_buffer: unsupported buffer sizes");
  end

  // pin synchronisers
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  logic          access_d_r;

  wire [PW-1:0] pin_raw = {i_host_type_select_pins, i_register_chip_select_n,
                           i_memory_chip_select_n, i_host_read_n, i_host_write_n,
                           i_host_addr, i_host_data};
  wire [SEL_W-1:0]  sel_s  = pin_s2_r[PW-1 -: SEL_W];
  wire              rcs_s  = ~pin_s2_r[PW-SEL_W-1];
  wire              mcs_s  = ~pin_s2_r[PW-SEL_W-2];
  wire              rd_s   = ~pin_s2_r[PW-SEL_W-3];
  wire              wr_s   = ~pin_s2_r[PW-SEL_W-4];
  wire [ADDR_W-1:0] addr_s = pin_s2_r[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] data_s = pin_s2_r[DATA_W-1:0];
  wire              access = (rcs_s | mcs_s) & (rd_s | wr_s);
  wire              start  = access & ~access_d_r;

  always_ff @(posedge i_clock) begin
    pin_s1_r   <= pin_raw;
    pin_s2_r   <= pin_s1_r;
    access_d_r <= i_rst_n & access;
  end

  // strap capture
  logic [1:0]       strap_cnt_r;
  logic [SEL_W-1:0] host_type_r;
  logic             type_valid_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      strap_cnt_r  <= 2'h0;
      host_type_r  <= SEL_W'(ht_wide_sep);
      type_valid_r <= 1'b0;
    end else if (!type_valid_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == STRAP_CAPTURE_CYCLES) begin
        host_type_r  <= sel_s;
        type_valid_r <= 1'b1;
      end
    end
  end

  assign o_host_type          = host_type_r;
  assign o_host_type_valid    = type_valid_r;
  assign o_host_type_reserved = type_valid_r & (host_type_r == SEL_W'(ht_reserved));

  // fetch memories
  logic [ADDR_W-1:0] fa_r [ENTRIES];
  logic [DATA_W-1:0] fd_r [ENTRIES];
  logic [ENTRIES-1:0] fv_r;
  logic [IDX_W-1:0]   victim_r;

  function automatic logic [ENTRIES-1:0] fetch_match(input logic [ADDR_W-1:0] a);
    logic [ENTRIES-1:0] m;
    m = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      m[i] = fv_r[i] & (fa_r[i] == a);
    end
    return m;
  endfunction : fetch_match

  // access sequencer
  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic              is_wr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;

  // function reads the entry arrays, so a process keeps the match current
  logic [ENTRIES-1:0] hit_vec;

  always_comb begin
    hit_vec = fetch_match(addr_s);
  end

  wire               hit     = |hit_vec;
  logic [DATA_W-1:0] hit_data;

  always_comb begin
    hit_data = DATA_RST;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hit_vec[i]) begin
        hit_data = fd_r[i];
      end
    end
  end

  // write queue: address and data travel together
  logic          q_push_ready;
  logic          q_pop_valid;
  logic [QW-1:0] q_pop_data;
  logic          q_empty;
  wire           q_push = (state_r == st_wr_push);

  write_queue #(
    .WIDTH (QW),
    .DEPTH (FIFO_DEPTH)
  ) u_write_queue (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_push_valid (q_push),
    .o_push_ready (q_push_ready),
    .i_push_data  ({addr_r, wdata_r}),
    .o_pop_valid  (q_pop_valid),
    .i_pop_ready  (i_mem_gnt),
    .o_pop_data   (q_pop_data),
    .o_full       (),
    .o_empty      (q_empty)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle: begin
        if (start && rcs_s) begin
          state_nxt = st_reg;
        end else if (start && wr_s) begin
          state_nxt = st_wr_push;
        end else if (start && hit) begin
          state_nxt = st_done;
        end else if (start) begin
          state_nxt = st_rd_drain;
        end
      end
      st_reg:      state_nxt = i_reg_ack ? st_done : st_reg;
      st_wr_push:  state_nxt = q_push_ready ? st_done : st_wr_push;
      st_rd_drain: state_nxt = q_empty ? st_rd_req : st_rd_drain;
      st_rd_req:   state_nxt = i_mem_gnt ? st_rd_data : st_rd_req;
      st_rd_data:  state_nxt = i_mem_rvalid ? st_done : st_rd_data;
      st_done:     state_nxt = access ? st_done : st_idle;
      default:     state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_r <= st_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      is_wr_r <= 1'b0;
      addr_r  <= ADDR_RST;
      wdata_r <= DATA_RST;
    end else if (state_r == st_idle && start) begin
      is_wr_r <= wr_s;
      addr_r  <= addr_s;
      wdata_r <= data_s;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rdata_r <= DATA_RST;
    end else if (state_r == st_idle && start && rd_s && !rcs_s && hit) begin
      rdata_r <= hit_data;
    end else if (state_r == st_rd_data && i_mem_rvalid) begin
      rdata_r <= i_mem_rdata;
    end else if (state_r == st_reg && i_reg_ack && !is_wr_r) begin
      rdata_r <= i_reg_rdata;
    end
  end

  // fetch entry upkeep
  logic [ENTRIES-1:0] inval_vec;

  always_comb begin
    inval_vec = q_push ? fetch_match(addr_r) : '0;
  end

  wire               fill      = (state_r == st_rd_data) & i_mem_rvalid;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      fv_r     <= '0;
      victim_r <= '0;
    end else begin
      fv_r <= fv_r & ~inval_vec;
      if (fill) begin
        fv_r[victim_r] <= 1'b1;
        victim_r       <= victim_r + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (fill) begin
      fa_r[victim_r] <= addr_r;
      fd_r[victim_r] <= i_mem_rdata;
    end
  end

  // host side outputs
  // write completes once queued
  assign o_host_ready   = (state_r == st_done);
  assign o_host_data    = rdata_r;
  assign o_host_data_oe = (state_r == st_done) & ~is_wr_r;

  // register side
  assign o_reg_req   = (state_r == st_reg);
  assign o_reg_write = is_wr_r;
  assign o_reg_addr  = addr_r[REG_ADDR_W-1:0];
  assign o_reg_wdata = wdata_r;

  // memory side: queued writes before reads
  // 16-bit words to the arbiter
  assign o_mem_req   = q_pop_valid | (state_r == st_rd_req);
  assign o_mem_write = q_pop_valid;
  assign o_mem_addr  = q_pop_valid ? q_pop_data[DATA_W +: ADDR_W] : addr_r;
  assign o_mem_wdata = q_pop_data[DATA_W-1:0];

endmodule : host_port_fetch_buffer

`default_nettype wire

// ### verification/hpfb_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module hpfb_checker (
  // clock and reset
  input wire logic                            i_clock,
  input wire logic                            i_rst_n,
  // watched ports
  input wire logic [host_port_pkg::SEL_W-1:0] o_host_type,
  input wire logic                            o_host_type_valid,
  input wire logic                            o_host_type_reserved,
  input wire logic                            o_host_data_oe,
  input wire logic                            o_host_ready,
  input wire logic                            o_reg_req,
  input wire logic [host_port_pkg::REG_ADDR_W-1:0] o_reg_addr,
  input wire logic                            i_reg_ack,
  input wire logic                            o_mem_req,
  input wire logic [host_port_pkg::ADDR_W-1:0] o_mem_addr,
  input wire logic                            i_mem_gnt,
  input wire logic                            i_mem_rvalid
);
  import host_port_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_reg_done;
    o_reg_req && i_reg_ack;
  endsequence
  sequence s_rd_back;
    i_mem_rvalid;
  endsequence
  sequence s_answer;
    o_host_ready && o_host_data_oe;
  endsequence

  property p_strap_take;
    $rose(i_rst_n) |-> ##[2:6] o_host_type_valid;
  endproperty
  a_strap_take: assert property (p_strap_take)
    else $error("strap not captured in time");
  property p_strap_hold;
    o_host_type_valid |=> o_host_type_valid && $stable(o_host_type);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("captured style changed");
  property p_reserved;
    o_host_type_valid |-> (o_host_type_reserved == (o_host_type == 3'h2));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved flag wrong");
  property p_reg_hold;
    o_reg_req && !i_reg_ack |=> o_reg_req && $stable(o_reg_addr);
  endproperty
  a_reg_hold: assert property (p_reg_hold)
    else $error("register request dropped early");
  property p_reg_end;
    s_reg_done |=> !o_reg_req && o_host_ready;
  endproperty
  a_reg_end: assert property (p_reg_end)
    else $error("register access not ended");
  property p_mem_hold;
    o_mem_req && !i_mem_gnt |=> o_mem_req && $stable(o_mem_addr);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped early");
  property p_miss_ret;
    s_rd_back |=> s_answer;
  endproperty
  a_miss_ret: assert property (p_miss_ret)
    else $error("fetched word not returned");
  property p_oe_ready;
    o_host_data_oe |-> o_host_ready;
  endproperty
  a_oe_ready: assert property (p_oe_ready)
    else $error("data driven without ready");
endmodule : hpfb_checker

bind host_port_fetch_buffer hpfb_checker u_chk (
  .i_clock, .i_rst_n, .o_host_type, .o_host_type_valid, .o_host_type_reserved,
  .o_host_data_oe, .o_host_ready, .o_reg_req, .o_reg_addr, .i_reg_ack,
  .o_mem_req, .o_mem_addr, .i_mem_gnt, .i_mem_rvalid
);
`default_nettype wire

// ### verification/shared_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

module shared_mem_model #(
  parameter int LAT = 2
) (
  // clock, reset and stall
  input  wire logic                                i_clock,
  input  wire logic                                i_rst_n,
  input  wire logic                                i_stall,
  // register file side
  input  wire logic                                i_reg_req,
  input  wire logic                                i_reg_write,
  input  wire logic [host_port_pkg::REG_ADDR_W-1:0] i_reg_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0]    i_reg_wdata,
  output logic                                     o_reg_ack,
  output logic      [host_port_pkg::DATA_W-1:0]    o_reg_rdata,
  // arbiter side
  input  wire logic                                i_mem_req,
  input  wire logic                                i_mem_write,
  input  wire logic [host_port_pkg::ADDR_W-1:0]    i_mem_addr,
  input  wire logic [host_port_pkg::DATA_W-1:0]    i_mem_wdata,
  output logic                                     o_mem_gnt,
  output logic                                     o_mem_rvalid,
  output logic      [host_port_pkg::DATA_W-1:0]    o_mem_rdata
);
  import host_port_pkg::*;
  logic [DATA_W-1:0] mem  [256];
  logic [DATA_W-1:0] regs [256];
  int                cnt;

  always_ff @(posedge i_clock) begin
    o_mem_gnt    <= 1'b0;
    o_mem_rvalid <= 1'b0;
    o_reg_ack    <= 1'b0;
    o_mem_rdata  <= ~o_mem_rdata;
    o_reg_rdata  <= ~o_reg_rdata;
    if (!i_rst_n) begin
      cnt         <= 0;
      o_mem_rdata <= '0;
      o_reg_rdata <= '0;
    end else begin
      // grant after delay, data from memory
      if (o_mem_gnt) begin
        if (i_mem_write) begin
          mem[i_mem_addr[7:0]] <= i_mem_wdata;
        end else begin
          o_mem_rvalid <= 1'b1;
          o_mem_rdata  <= mem[i_mem_addr[7:0]];
        end
      end else if (i_mem_req && !i_stall) begin
        cnt <= cnt + 1;
        if (cnt >= LAT) begin
          o_mem_gnt <= 1'b1;
          cnt       <= 0;
        end
      end
      if (i_reg_req && !o_reg_ack) begin
        o_reg_ack   <= 1'b1;
        o_reg_rdata <= regs[i_reg_addr];
        if (i_reg_write) begin
          regs[i_reg_addr] <= i_reg_wdata;
        end
      end
    end
  end
endmodule : shared_mem_model
`default_nettype wire

// ### verification/tb_host_port_fetch_buffer.sv
`timescale 1ns/100ps
`default_nettype none

module tb_host_port_fetch_buffer;
  import host_port_pkg::*;
  logic              i_clock = 1'b0;
  logic              i_rst_n = 1'b0;
  logic [SEL_W-1:0]  i_host_type_select_pins = '0;
  logic              i_register_chip_select_n = 1'b1;
  logic              i_memory_chip_select_n = 1'b1;
  logic              i_host_read_n = 1'b1;
  logic              i_host_write_n = 1'b1;
  logic [ADDR_W-1:0] i_host_addr = '0;
  logic [DATA_W-1:0] i_host_data = '0;
  logic              stall = 1'b0;
  logic [SEL_W-1:0]  o_host_type;
  logic [DATA_W-1:0] o_host_data, o_reg_wdata, i_reg_rdata, o_mem_wdata, i_mem_rdata;
  logic [ADDR_W-1:0] o_mem_addr;
  logic [7:0]        o_reg_addr;
  logic o_host_type_valid, o_host_type_reserved, o_host_data_oe, o_host_ready, o_reg_req;
  logic o_reg_write, i_reg_ack, o_mem_req, o_mem_write, i_mem_gnt, i_mem_rvalid;
  int                mismatches = 0;
  int                checks = 0;
  logic [DATA_W-1:0] q;
  int                n, m;

  host_port_fetch_buffer DUT (.i_clock, .i_rst_n, .i_host_type_select_pins, .o_host_type,
    .o_host_type_valid, .o_host_type_reserved, .i_register_chip_select_n,
    .i_memory_chip_select_n, .i_host_read_n, .i_host_write_n, .i_host_addr, .i_host_data,
    .o_host_data, .o_host_data_oe, .o_host_ready, .o_reg_req, .o_reg_write, .o_reg_addr,
    .o_reg_wdata, .i_reg_ack, .i_reg_rdata, .o_mem_req, .o_mem_write, .o_mem_addr,
    .o_mem_wdata, .i_mem_gnt, .i_mem_rvalid, .i_mem_rdata);
  shared_mem_model u_far (.i_clock, .i_rst_n, .i_stall(stall), .i_reg_req(o_reg_req),
    .i_reg_write(o_reg_write), .i_reg_addr(o_reg_addr), .i_reg_wdata(o_reg_wdata),
    .o_reg_ack(i_reg_ack), .o_reg_rdata(i_reg_rdata), .i_mem_req(o_mem_req),
    .i_mem_write(o_mem_write), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
    .o_mem_gnt(i_mem_gnt), .o_mem_rvalid(i_mem_rvalid), .o_mem_rdata(i_mem_rdata));

  initial begin
    forever #50 i_clock = ~i_clock;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_less(input int a, input int b);
    checks++;
    if (!(a < b)) begin
      mismatches++;
      $display("ERROR t=%0t %h not below %h", $time, a, b);
    end
  endtask : chk_less

  task automatic wait_rdy(input logic v, output int k);
    k = 0;
    while (o_host_ready !== v && k < 300) begin
      @(negedge i_clock);
      k++;
    end
    if (k >= 300) begin
      mismatches++;
      test_done();
    end
  endtask : wait_rdy

  // one host access, strobes held until ready
  task automatic acc(input logic w, input logic mc, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r, output int k);
    int j;
    @(posedge i_clock);
    i_memory_chip_select_n   <= ~mc;
    i_register_chip_select_n <= mc;
    i_host_write_n           <= ~w;
    i_host_read_n            <= w;
    i_host_addr              <= a;
    i_host_data              <= d;
    wait_rdy(1'b1, k);
    r = o_host_data;
    @(posedge i_clock);
    i_memory_chip_select_n   <= 1'b1;
    i_register_chip_select_n <= 1'b1;
    i_host_write_n           <= 1'b1;
    i_host_read_n            <= 1'b1;
    wait_rdy(1'b0, j);
  endtask : acc

  task automatic do_rst(input logic [SEL_W-1:0] c);
    @(posedge i_clock);
    i_rst_n                 <= 1'b0;
    i_host_type_select_pins <= c;
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clock);
  endtask : do_rst

  task automatic t_styles;
    for (int c = 0; c < 8; c++) begin
      do_rst(3'(c));
      chk_val(16'(o_host_type), 16'(c));
      chk_val(16'(o_host_type_valid), 16'h0001);
      chk_val(16'(o_host_type_reserved), 16'(c == 2));
      acc(1'b1, 1'b1, 24'h00_0020 + 24'(c), 16'h5a50 + 16'(c), q, n);
      acc(1'b0, 1'b1, 24'h00_0020 + 24'(c), '0, q, n);
      chk_val(q, 16'h5a50 + 16'(c));
    end
    $display("t_styles done");
  endtask : t_styles

  task automatic t_reg;
    acc(1'b1, 1'b0, 24'h12_3456, 16'hbeef, q, n);
    acc(1'b0, 1'b0, 24'hff_0056, '0, q, n);
    chk_val(q, 16'hbeef);
    $display("t_reg done");
  endtask : t_reg

  task automatic t_hit;
    acc(1'b1, 1'b1, 24'h00_0040, 16'h1111, q, n);
    acc(1'b0, 1'b1, 24'h00_0040, '0, q, m);
    chk_val(q, 16'h1111);
    acc(1'b0, 1'b1, 24'h00_0040, '0, q, n);
    chk_val(q, 16'h1111);
    chk_less(n, m);
    acc(1'b1, 1'b1, 24'h00_0040, 16'h2222, q, n);
    acc(1'b0, 1'b1, 24'h00_0040, '0, q, n);
    chk_val(q, 16'h2222);
    $display("t_hit done");
  endtask : t_hit

  task automatic t_four;
    int miss [4];
    for (int i = 0; i < 4; i++) acc(1'b1, 1'b1, 24'h00_0080 + 24'(i), 16'h8000 + 16'(i), q, n);
    for (int i = 0; i < 4; i++) acc(1'b0, 1'b1, 24'h00_0080 + 24'(i), '0, q, miss[i]);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 1'b1, 24'h00_0080 + 24'(i), '0, q, n);
      chk_val(q, 16'h8000 + 16'(i));
      chk_less(n, miss[i]);
    end
    $display("t_four done");
  endtask : t_four

  task automatic t_full;
    @(posedge i_clock);
    stall <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b1, 24'h00_0100 + 24'(i), 16'hc000 + 16'(i), q, n);
      chk_less(n, 8);
    end
    fork
      acc(1'b1, 1'b1, 24'h00_0104, 16'hc004, q, n);
      begin
        repeat (30) @(posedge i_clock);
        stall <= 1'b0;
      end
    join
    chk_less(29, n);
    for (int i = 0; i < 5; i++) begin
      acc(1'b0, 1'b1, 24'h00_0100 + 24'(i), '0, q, n);
      chk_val(q, 16'hc000 + 16'(i));
    end
    $display("t_full done");
  endtask : t_full

  initial begin
    t_styles();
    t_reg();
    t_hit();
    t_four();
    t_full();
    test_done();
  end
endmodule : tb_host_port_fetch_buffer
`default_nettype wire
